/* File: core/fault_pkg.sv */
// Constants and carriers for the LED fault-protection sequencer.
// Assumes a 200 MHz system clock; analogue comparators arrive as raw levels.
package fault_pkg;
  localparam int          LANES        = 6;
  localparam int          TIMEOUT_PWM  = 6;
  localparam int          CLK_MHZ      = 200;
  localparam int          SHUTDOWN_MS  = 31;
  localparam int          SHUTDOWN_CYC = SHUTDOWN_MS * 1000 * CLK_MHZ;
  localparam logic [7:0]  SCALE_FULL   = 8'hff;
  localparam logic [7:0]  SCALE_FIRST  = 8'hc2;
  localparam logic [7:0]  SCALE_STEP   = 8'h10;
  localparam logic [7:0]  SCALE_FLOOR  = 8'h20;
  localparam int          ST_FAULT     = 0;
  localparam int          ST_THERMAL   = 1;
  localparam int          ST_OVCURR    = 2;
  localparam int          ST_LANE_SD   = 3;
  localparam int          ST_WIDTH     = 8;

  typedef enum {INJECT, RUN, HOT, DEAD} phase_e;

  typedef struct packed {
    logic            sw_over_limit;
    logic            switch_node_ok;
    logic            ovp_over_target;
    logic            ovp_below_fifth;
    logic            temp_low_trip;
    logic            temp_high_trip;
    logic            cooled;
    logic            input_overcurrent;
  } sense_s;

  // Comparator idle levels: an unpowered output sits below a fifth of its limit
  localparam sense_s      SENSE_IDLE   = '{ovp_below_fifth: 1'b1, default: 1'b0};

  typedef struct packed {
    logic [LANES-1:0] below_target;
    logic [LANES-1:0] over_short;
  } lane_sense_s;
endpackage

/* File: core/led_fault_protection_ctrl.sv */
// LED backlight fault-protection sequencer: start-up checks, thermal response,
// per-lane open/short time-out and thermal current foldback.
// Assumes comparator levels arrive asynchronously and pwm_period_tick is on sys_clk.
`timescale 1ns/1ps

// What this block does
// - Switch off when current over limit
// - Inject current; wait switch node above threshold
// - Protection transistor off on rise-then-fall
// - Lower temperature: weak lanes time out
// - Upper temperature stops boost and sources
// - Upper temperature sets thermal status bit
// - Status stays readable during thermal shutdown
// - Over-short lane disabled after six periods
// - Lane below short threshold stays enabled
// - Recovery at reduced scale, lower each trip down to a floor
// - Open lane at overvoltage times out
// - Overvoltage disables weak lanes that lane_mask enables, after six periods in RUN
// - Shorted output: permanent shutdown after 31 ms
// - Input overcurrent kills lanes, latches cause
module led_fault_protection_ctrl
  import fault_pkg::*;
#(
  parameter int SHUTDOWN_CYCLES = SHUTDOWN_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             enable,
  input  wire logic             pwm_period_tick,
  input  wire sense_s           sense_raw,
  input  wire lane_sense_s      lane_raw,
  input  wire logic [LANES-1:0] lane_mask,
  output logic                  boost_gate_on,
  output logic                  inject_current_on,
  output logic                  protect_fet_on,
  output logic [LANES-1:0]      lane_enable,
  output logic [7:0]            current_scale,
  output logic [ST_WIDTH-1:0]   fault_status,
  output logic                  ctrl_alive
);

  sense_s      s_meta, s;
  lane_sense_s l_meta, l;
  phase_e      phase, next_phase;
  logic [$clog2(SHUTDOWN_CYCLES+1)-1:0] up_cnt, next_up_cnt;
  logic [2:0]  to_cnt [LANES];
  logic [2:0]  next_to_cnt [LANES];
  logic [LANES-1:0] disabled, next_disabled;
  logic        ovp_armed, next_ovp_armed;
  logic        fet_off, next_fet_off;
  logic [7:0]  scale, next_scale;
  logic [ST_WIDTH-1:0] status, next_status;
  logic        switching, next_switching;
  logic [LANES-1:0] lane_fault;

  // Two-stage synchronisers for comparator levels
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // Idle levels, so the first flushed sample cannot look like an overvoltage fall
      s_meta <= SENSE_IDLE;
      s      <= SENSE_IDLE;
      l_meta <= '0;
      l      <= '0;
    end else begin
      s_meta <= sense_raw;
      s      <= s_meta;
      l_meta <= lane_raw;
      l      <= l_meta;
    end
  end

  // A lane counts only while its fault stands; masked or shut lanes never count
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      lane_fault[i] = lane_mask[i] && !disabled[i] &&
                      (l.over_short[i] ||
                       (l.below_target[i] && (s.temp_low_trip || s.ovp_over_target)));
    end
  end

  always_comb begin
    next_phase     = phase;
    next_up_cnt    = up_cnt;
    next_ovp_armed = ovp_armed;
    next_fet_off   = fet_off;
    next_scale     = scale;
    next_status    = status;
    next_disabled  = disabled;
    for (int i = 0; i < LANES; i++) next_to_cnt[i] = to_cnt[i];
    if (up_cnt < SHUTDOWN_CYCLES[$bits(up_cnt)-1:0]) next_up_cnt = up_cnt + 1'b1;
    // Armed once the output has climbed past a fifth of its limit
    if (!s.ovp_below_fifth) next_ovp_armed = 1'b1;
    if (ovp_armed && s.ovp_below_fifth) next_fet_off = 1'b1;
    if (s.input_overcurrent) next_status[ST_OVCURR] = 1'b1;
    case (phase)
      INJECT: begin
        if (s.switch_node_ok) next_phase = RUN;
        else if (up_cnt >= SHUTDOWN_CYCLES[$bits(up_cnt)-1:0]) next_phase = DEAD;
      end
      RUN: begin
        // Clearing wins even when a thermal or overcurrent branch below takes over
        for (int i = 0; i < LANES; i++) begin
          if (!lane_fault[i]) next_to_cnt[i] = 3'd0;
        end
        if (s.input_overcurrent || next_fet_off) begin
          next_phase = DEAD;
        end else if (s.temp_high_trip) begin
          next_phase = HOT;
          next_status[ST_THERMAL] = 1'b1;
          // Each trip lowers the recovery scale, floored so lanes never go dark
          if (scale == SCALE_FULL) next_scale = SCALE_FIRST;
          else if (scale > SCALE_FLOOR + SCALE_STEP) next_scale = scale - SCALE_STEP;
          else next_scale = SCALE_FLOOR;
        end else begin
          for (int i = 0; i < LANES; i++) begin
            if (lane_fault[i] && pwm_period_tick) begin
              if (to_cnt[i] == 3'(TIMEOUT_PWM - 1)) next_disabled[i] = 1'b1;
              else next_to_cnt[i] = to_cnt[i] + 3'd1;
            end
          end
        end
      end
      HOT: begin
        if (s.cooled && !s.temp_high_trip) begin
          next_phase    = RUN;
          next_disabled = '0;
          for (int i = 0; i < LANES; i++) next_to_cnt[i] = 3'd0;
        end
      end
      DEAD: next_phase = DEAD;
      default: next_phase = INJECT;
    endcase
    next_status[ST_LANE_SD] = |next_disabled;
    next_status[ST_FAULT]   = next_status[ST_THERMAL] | next_status[ST_OVCURR] | (|next_disabled) |
                              (next_phase == DEAD);
  end

  // Cycle-by-cycle limit acts on the synchronised comparator
  always_comb begin
    // Follows the next phase so switching stops on the very edge that leaves RUN
    next_switching = (next_phase == RUN) && !s.sw_over_limit;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !enable) begin
      phase     <= INJECT;
      up_cnt    <= '0;
      ovp_armed <= 1'b0;
      fet_off   <= 1'b0;
      scale     <= SCALE_FULL;
      status    <= '0;
      disabled  <= '0;
      switching <= 1'b0;
      for (int i = 0; i < LANES; i++) to_cnt[i] <= 3'd0;
    end else begin
      phase     <= next_phase;
      up_cnt    <= next_up_cnt;
      ovp_armed <= next_ovp_armed;
      fet_off   <= next_fet_off;
      scale     <= next_scale;
      status    <= next_status;
      disabled  <= next_disabled;
      switching <= next_switching;
      for (int i = 0; i < LANES; i++) to_cnt[i] <= next_to_cnt[i];
    end
  end

  assign boost_gate_on     = switching && !s.sw_over_limit;
  assign inject_current_on = (phase == INJECT);
  assign protect_fet_on    = !fet_off && (phase != DEAD);
  assign lane_enable       = (phase == RUN) ? (lane_mask & ~disabled) : '0;
  assign current_scale     = scale;
  assign fault_status      = status;
  assign ctrl_alive        = enable;

  chk_limit_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s.sw_over_limit |-> !boost_gate_on) else $error("gate on above limit");
  chk_inject_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
    phase == INJECT |-> !boost_gate_on && lane_enable == '0) else $error("started before node ok");
  chk_fet_fall: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    ovp_armed && s.ovp_below_fifth |=> !protect_fet_on) else $error("fet stayed on");
  chk_hot_off: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    phase == RUN && s.temp_high_trip && !s.input_overcurrent && !fet_off && !s.ovp_below_fifth
    |=> lane_enable == '0 && !boost_gate_on) else $error("not off when hot");
  chk_thermal_bit: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    phase == HOT |-> fault_status[ST_THERMAL]) else $error("thermal bit clear");
  chk_alive_hot: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    phase == HOT |-> ctrl_alive && fault_status[ST_THERMAL] && fault_status[ST_FAULT]) else $error("control not alive");
  chk_scale_drop: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    phase == RUN && $past(phase) == HOT |-> current_scale < SCALE_FULL) else $error("no foldback");
  chk_timeout_len: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    $rose(disabled[0]) |-> $past(to_cnt[0]) == 3'(TIMEOUT_PWM - 1)) else $error("timeout length");
  chk_clear_reset: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    phase == RUN && !l.over_short[0] && !l.below_target[0] |=> to_cnt[0] == 3'd0) else $error("count kept");
  chk_dead_latch: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    phase == DEAD |=> phase == DEAD && lane_enable == '0) else $error("left shutdown");

  // Last counted period of lane 0, with its fault still standing
  sequence lane0_last_tick;
    phase == RUN && pwm_period_tick && to_cnt[0] == 3'(TIMEOUT_PWM - 1);
  endsequence
  sequence lane0_faulted;
    lane_mask[0] && !disabled[0] &&
    (l.over_short[0] || (l.below_target[0] && (s.temp_low_trip || s.ovp_over_target)));
  endsequence
  chk_lane_off: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    lane0_last_tick ##0 lane0_faulted |=> !lane_enable[0]) else $error("lane not shut off");
  chk_lane_sd_bit: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    |disabled |-> fault_status[ST_LANE_SD] && fault_status[ST_FAULT]) else $error("lane bit clear");
  chk_clean_lane: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    phase == RUN && !disabled[0] && !l.over_short[0] && !l.below_target[0]
    |=> lane_enable[0] == lane_mask[0] || phase != RUN) else $error("clean lane dropped");
  chk_node_start: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    phase == INJECT && s.switch_node_ok |=> !inject_current_on) else $error("no start on node ok");
  chk_startup_timeout: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    phase == INJECT && !s.switch_node_ok && up_cnt >= SHUTDOWN_CYCLES[$bits(up_cnt)-1:0]
    |=> phase == DEAD && !inject_current_on && !protect_fet_on) else $error("no start-up shutdown");
  chk_oc_latch: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    s.input_overcurrent |=> fault_status[ST_OVCURR] && fault_status[ST_FAULT]) else $error("cause not latched");
  chk_oc_lanes: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    phase == RUN && s.input_overcurrent |=> lane_enable == '0 && !boost_gate_on) else $error("lanes on in overcurrent");
  chk_scale_floor: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    current_scale >= SCALE_FLOOR) else $error("scale under floor");
  chk_fet_armed: assert property (@(posedge sys_clk) disable iff (!rst_n || !enable)
    !ovp_armed && !fet_off |=> !fet_off) else $error("fet off without rise");
endmodule

/* File: verif/led_string_model.sv */
// Far side: boost output capacitor and switch node.
// Assumes the bench sets comparator levels on cmd.
`timescale 1ns/1ps
module led_string_model
  import fault_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   inject_current_on,
  input  wire logic   node_short,
  input  wire sense_s cmd,
  output sense_s      sense_raw
);
  logic [2:0] charge = 3'h0;
  // A grounded node never charges, however long the current is injected
  always @(negedge sys_clk) begin
    if (node_short) begin
      charge <= 3'h0;
    end else if (inject_current_on && charge != 3'h7) begin
      charge <= charge + 3'h1;
    end
  end
  always_comb begin
    sense_raw = cmd;
    sense_raw.switch_node_ok = (charge == 3'h7);
  end
endmodule

/* File: verif/test_led_fault_protection_ctrl.sv */
// Bench for the fault sequencer.
// Assumes inputs change on the falling edge.
`timescale 1ns/1ps
module test_led_fault_protection_ctrl;
  import fault_pkg::*;
  localparam int SD = 50;
  typedef struct {logic [5:0] sh, wk; logic lo, ov; int n; logic [7:0] en;} row_s;
  logic sys_clk = 1'b0, rst_n = 1'b0, tick = 1'b0, node_short = 1'b0;
  sense_s cmd = '0;
  logic enable = 1'b1;
  logic [LANES-1:0] lane_mask = 6'h3f;
  sense_s sense_raw;
  lane_sense_s lane_raw = '0;
  logic boost_gate_on, inject_current_on, protect_fet_on, ctrl_alive;
  logic [LANES-1:0] lane_enable;
  logic [7:0] current_scale;
  logic [ST_WIDTH-1:0] fault_status;
  int failures = 0, tests_run = 0;
  row_s rows [5] = '{'{6'h01, 6'h00, 0, 0, 6, 8'h3e}, '{6'h20, 6'h00, 0, 0, 5, 8'h3f},
    '{6'h00, 6'h02, 0, 0, 6, 8'h3f}, '{6'h00, 6'h02, 1, 0, 6, 8'h3d}, '{6'h00, 6'h04, 0, 1, 6, 8'h3b}};
  always #2.5 sys_clk = ~sys_clk;
  led_fault_protection_ctrl #(.SHUTDOWN_CYCLES(SD)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .enable(enable), .pwm_period_tick(tick), .sense_raw(sense_raw), .lane_raw(lane_raw),
    .lane_mask(lane_mask), .boost_gate_on(boost_gate_on), .inject_current_on(inject_current_on),
    .protect_fet_on(protect_fet_on), .lane_enable(lane_enable), .current_scale(current_scale),
    .fault_status(fault_status), .ctrl_alive(ctrl_alive));
  led_string_model i_far (.sys_clk(sys_clk), .inject_current_on(inject_current_on),
    .node_short(node_short), .cmd(cmd), .sense_raw(sense_raw));
  task automatic check(input string name, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(1);
    end
  endtask
  task automatic start();
    rst_n = 1'b0;
    cmd = '0;
    lane_raw = '0;
    cyc(3);
    rst_n = 1'b1;
    cyc(12);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Whole run is under 600 cycles
  initial begin
    #20000;
    failures++;
    report_and_stop();
  end
  initial begin
    cyc(20);
    check("rst_status", fault_status, 8'h00);
    check("rst_scale", current_scale, 8'hff);
    foreach (rows[i]) begin
      start();
      lane_raw = '{below_target: rows[i].wk, over_short: rows[i].sh};
      cmd.temp_low_trip = rows[i].lo;
      cmd.ovp_over_target = rows[i].ov;
      cyc(4);
      ticks(rows[i].n);
      cyc(2);
      check("lane_enable", {2'h0, lane_enable}, rows[i].en);
    end
    start();
    lane_raw.over_short = 6'h08;
    cyc(4);
    ticks(5);
    lane_raw.over_short = 6'h00;
    cyc(4);
    lane_raw.over_short = 6'h08;
    cyc(4);
    ticks(5);
    check("restart", {2'h0, lane_enable}, 8'h3f);
    check("inject_run", {7'h0, inject_current_on}, 8'h00);
    check("boost_on", {7'h0, boost_gate_on}, 8'h01);
    cmd.sw_over_limit = 1'b1;
    cyc(3);
    check("boost_lim", {7'h0, boost_gate_on}, 8'h00);
    cmd = '{temp_high_trip: 1'b1, default: 1'b0};
    cyc(4);
    check("hot_lanes", {2'h0, lane_enable}, 8'h00);
    check("hot_status", fault_status, 8'h03);
    check("alive", {7'h0, ctrl_alive}, 8'h01);
    for (int k = 0; k < 2; k++) begin
      cmd = '{cooled: 1'b1, default: 1'b0};
      cyc(4);
      check("scale", current_scale, SCALE_FIRST - 8'(k) * SCALE_STEP);
      check("cool_lanes", {2'h0, lane_enable}, 8'h3f);
      cmd = '{temp_high_trip: 1'b1, default: 1'b0};
      cyc(4);
    end
    enable = 1'b0;
    cyc(2);
    check("off_alive", {7'h0, ctrl_alive}, 8'h00);
    check("off_status", fault_status, 8'h00);
    enable = 1'b1;
    start();
    cmd.ovp_over_target = 1'b1;
    cyc(4);
    cmd = '{ovp_below_fifth: 1'b1, default: 1'b0};
    cyc(4);
    check("protect", {7'h0, protect_fet_on}, 8'h00);
    start();
    cmd.input_overcurrent = 1'b1;
    cyc(4);
    check("oc_lanes", {2'h0, lane_enable}, 8'h00);
    check("oc_status", fault_status, 8'h05);
    start();
    lane_mask = 6'h3e;
    lane_raw.over_short = 6'h01;
    cyc(4);
    ticks(6);
    check("masked", {2'h0, lane_enable}, 8'h3e);
    check("masked_status", fault_status, 8'h00);
    lane_mask = 6'h3f;
    node_short = 1'b1;
    start();
    check("inject_wait", {7'h0, inject_current_on}, 8'h01);
    cyc(SD);
    check("dead", {7'h0, inject_current_on}, 8'h00);
    check("dead_lanes", {2'h0, lane_enable}, 8'h00);
    check("dead_status", fault_status, 8'h01);
    report_and_stop();
  end
endmodule
